//--- hw/ssfl_pkg.sv
// Register map, field positions and reset values of the serial status block
package ssfl_pkg;
  localparam int          DATA_W        = 32;
  localparam int          ADDR_W        = 12;
  localparam int          STAT_W        = 16;
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_STAT     = 12'h004;
  localparam logic [11:0] ADDR_DATA     = 12'h008;
  localparam int          CTRL_ON_POS   = 15;
  localparam int          CTRL_IGN_POS  = 3;
  localparam int          ST_FRAME_ERROR_FLAG_POS = 12;
  localparam int          ST_BUSY_POS   = 11;
  localparam int          ST_TUR_POS    = 8;
  localparam int          ST_IDLE_POS   = 7;
  localparam int          ST_ROV_POS    = 6;
  localparam int          ST_RXE_POS    = 5;
  localparam int          ST_TXE_POS    = 3;
  localparam int          ST_TXF_POS    = 1;
  localparam int          ST_RXF_POS    = 0;
  localparam logic        RST_ON        = 1'b0;
  localparam logic        RST_IGN       = 1'b0;
  localparam logic        RST_FLAG      = 1'b0;
  localparam logic [31:0] RST_WORD      = 32'h00000000;
endpackage

//--- hw/ssfl_sticky.sv
// Sticky flag: hardware set wins over a software clear in the same cycle
`timescale 1ns/1ps
module ssfl_sticky (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic setEvent,
  input  wire logic clearReq,
  output logic      flag
);
  logic next_flag;

  assign next_flag = setEvent | (flag & ~clearReq);

  always_ff @(posedge mclk) begin
    if (rst) begin
      flag <= ssfl_pkg::RST_FLAG;
    end else begin
      flag <= next_flag;
    end
  end
endmodule

//--- hw/ssfl_word_buffer.sv
// One-word holding buffer with full state; a load beats a drain
`timescale 1ns/1ps
module ssfl_word_buffer (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        loadReq,
  input  wire logic [31:0] loadWord,
  input  wire logic        drainReq,
  output logic             full,
  output logic [31:0]      word
);
  logic next_full;

  assign next_full = loadReq | (full & ~drainReq);

  always_ff @(posedge mclk) begin
    if (rst) begin
      full <= 1'b0;
      word <= ssfl_pkg::RST_WORD;
    end else begin
      full <= next_full;
      if (loadReq) begin
        word <= loadWord;
      end
    end
  end
endmodule

//--- hw/ssfl_status_low.sv
// Status flags of the serial unit with APB register access and holding buffers
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Contract
// - Bits 15..13 and 10..9 read zero
// - Frame error sets flag, software clears
// - Activity flag shows any transaction in progress
// - Underrun flag set and cleared by hardware
// - Shift idle when transmit buffer, shifter empty
// - Receive while buffer full sets overflow; not if the buffer is read in that cycle
// - Receive empty set on read, cleared on transfer
// - Underrun cleared when off; live when ignored
module ssfl_status_low (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxWordDone,
  input  wire logic [31:0] rxWord,
  input  wire logic        txWordTake,
  input  wire logic        txShiftBusy,
  input  wire logic        linkBusy,
  input  wire logic        frameErrorEvent,
  input  wire logic        underrunLive,
  output logic [31:0]      txWord,
  output logic             txWordValid,
  output logic             moduleOn,
  output logic             ignoreUnderrun,
  output logic             underrunHalt
);
  function automatic logic ssfl_hit(input logic [11:0] addr, input logic [11:0] base);
    ssfl_hit = (addr == base);
  endfunction

  logic        accessPhase;
  logic        setupPhase;
  logic        hitCtrl;
  logic        hitStat;
  logic        hitData;
  logic        unmapped;
  logic        wrCtrl;
  logic        wrStat;
  logic        wrData;
  logic        rdData;
  logic        frameErrorFlag;
  logic        rxOverflowFlag;
  logic        txUnderrunFlag;
  logic        next_txUnderrunFlag;
  logic        rxFull;
  logic        txFull;
  logic [31:0] rxBufWord;
  logic        rxLoad;
  logic        rxOverflowEvent;
  logic        txLoad;
  logic        shiftIdleFlag;
  logic        activityFlag;
  logic        clrFrameError;
  logic        clrRxOverflow;
  logic [15:0] statusWord;
  logic [31:0] ctrlWord;
  logic [31:0] readMux;

  // Zero-wait slave: read data captured in setup, answered in access
  assign setupPhase = psel & ~penable;
  assign accessPhase = psel & penable;
  assign pready = accessPhase;
  assign hitCtrl = ssfl_hit(paddr, ssfl_pkg::ADDR_CTRL);
  assign hitStat = ssfl_hit(paddr, ssfl_pkg::ADDR_STAT);
  assign hitData = ssfl_hit(paddr, ssfl_pkg::ADDR_DATA);
  assign unmapped = ~(hitCtrl | hitStat | hitData);
  assign pslverr = accessPhase & unmapped;
  assign wrCtrl = accessPhase & pwrite & hitCtrl;
  assign wrStat = accessPhase & pwrite & hitStat;
  assign wrData = accessPhase & pwrite & hitData;
  assign rdData = accessPhase & ~pwrite & hitData;

  // Clearable bits clear on a written zero; ones leave them alone
  assign clrFrameError = wrStat & ~pwdata[ssfl_pkg::ST_FRAME_ERROR_FLAG_POS];
  assign clrRxOverflow = wrStat & ~pwdata[ssfl_pkg::ST_ROV_POS];

  // Receive path: a word arriving on a full buffer is dropped and flagged, unless the buffer is read in that cycle
  assign rxOverflowEvent = rxWordDone & rxFull & ~rdData;
  assign rxLoad = rxWordDone & ~rxOverflowEvent;
  assign txLoad = wrData & ~txFull;

  ssfl_word_buffer u_rxBuf (
    .mclk     (mclk),
    .rst      (rst),
    .loadReq  (rxLoad),
    .loadWord (rxWord),
    .drainReq (rdData),
    .full     (rxFull),
    .word     (rxBufWord)
  );

  ssfl_word_buffer u_txBuf (
    .mclk     (mclk),
    .rst      (rst),
    .loadReq  (txLoad),
    .loadWord (pwdata),
    .drainReq (txWordTake),
    .full     (txFull),
    .word     (txWord)
  );

  assign txWordValid = txFull;

  ssfl_sticky u_frameErr (
    .mclk     (mclk),
    .rst      (rst),
    .setEvent (frameErrorEvent),
    .clearReq (clrFrameError),
    .flag     (frameErrorFlag)
  );

  ssfl_sticky u_rxOvf (
    .mclk     (mclk),
    .rst      (rst),
    .setEvent (rxOverflowEvent),
    .clearReq (clrRxOverflow),
    .flag     (rxOverflowFlag)
  );

  // Underrun is owned by hardware; software writes are ignored
  assign next_txUnderrunFlag = ~moduleOn ? 1'b0 :
                               ignoreUnderrun ? underrunLive :
                               (txUnderrunFlag | underrunLive);

  always_ff @(posedge mclk) begin
    if (rst) begin
      txUnderrunFlag <= ssfl_pkg::RST_FLAG;
    end else begin
      txUnderrunFlag <= next_txUnderrunFlag;
    end
  end

  // Halt only latches in normal mode; ignore mode keeps data moving
  assign underrunHalt = txUnderrunFlag & ~ignoreUnderrun;

  always_ff @(posedge mclk) begin
    if (rst) begin
      moduleOn       <= ssfl_pkg::RST_ON;
      ignoreUnderrun <= ssfl_pkg::RST_IGN;
    end else if (wrCtrl) begin
      moduleOn       <= pwdata[ssfl_pkg::CTRL_ON_POS];
      ignoreUnderrun <= pwdata[ssfl_pkg::CTRL_IGN_POS];
    end
  end

  assign shiftIdleFlag = ~txFull & ~txShiftBusy;
  assign activityFlag = linkBusy | ~shiftIdleFlag;

  always_comb begin
    statusWord = 16'h0000;
    statusWord[ssfl_pkg::ST_FRAME_ERROR_FLAG_POS] = frameErrorFlag;
    statusWord[ssfl_pkg::ST_BUSY_POS]   = activityFlag;
    statusWord[ssfl_pkg::ST_TUR_POS]    = txUnderrunFlag;
    statusWord[ssfl_pkg::ST_IDLE_POS]   = shiftIdleFlag;
    statusWord[ssfl_pkg::ST_ROV_POS]    = rxOverflowFlag;
    statusWord[ssfl_pkg::ST_RXE_POS]    = ~rxFull;
    statusWord[ssfl_pkg::ST_TXE_POS]    = ~txFull;
    statusWord[ssfl_pkg::ST_TXF_POS]    = txFull;
    statusWord[ssfl_pkg::ST_RXF_POS]    = rxFull;
  end

  always_comb begin
    ctrlWord = 32'h00000000;
    ctrlWord[ssfl_pkg::CTRL_ON_POS]  = moduleOn;
    ctrlWord[ssfl_pkg::CTRL_IGN_POS] = ignoreUnderrun;
  end

  assign readMux = hitCtrl ? ctrlWord :
                   hitStat ? {16'h0000, statusWord} :
                   hitData ? rxBufWord : 32'h00000000;

  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= ssfl_pkg::RST_WORD;
    end else if (setupPhase & ~pwrite) begin
      prdata <= readMux;
    end
  end
endmodule

//--- tb/ssfl_status_props.sv
// Port-level checks on the serial status block
`timescale 1ns/1ps
module ssfl_status_props (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        txWordValid,
  input wire logic        txWordTake,
  input wire logic        txShiftBusy,
  input wire logic        linkBusy,
  input wire logic        underrunLive,
  input wire logic        moduleOn,
  input wire logic        ignoreUnderrun,
  input wire logic        underrunHalt
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Status read data is the setup-cycle value, hence the $past
  wire rdAcc = psel && penable && !pwrite && paddr == ssfl_pkg::ADDR_STAT;
  a_unimpl_zero: assert property (rdAcc |-> prdata[15:13] == 3'h0 && prdata[10:9] == 2'h0)
    else $error("reserved status bits not zero");
  a_busy_read: assert property (
    rdAcc |-> prdata[11] == $past(linkBusy || txWordValid || txShiftBusy))
    else $error("activity bit wrong");
  a_idle_read: assert property (rdAcc |-> prdata[7] == $past(!txWordValid && !txShiftBusy))
    else $error("shift idle bit wrong");
  a_take_empties: assert property (txWordValid && txWordTake |=> !txWordValid)
    else $error("tx buffer still full after take");
  a_underrun_set: assert property (
    moduleOn && !ignoreUnderrun && underrunLive ##1 !ignoreUnderrun |-> underrunHalt)
    else $error("underrun not flagged");
  a_underrun_hold: assert property (
    underrunHalt && moduleOn |=> underrunHalt || ignoreUnderrun)
    else $error("underrun dropped while on");
  a_halt_cause: assert property ($rose(underrunHalt) |-> $past(underrunLive))
    else $error("halt raised without underrun");
  a_off_clears: assert property (!moduleOn |=> !underrunHalt)
    else $error("underrun kept while off");
  // Flag follows the live input one edge late, read latched one edge later
  a_ignore_live: assert property (
    rdAcc && $past(moduleOn, 2) && $past(ignoreUnderrun, 2)
    |-> prdata[8] == $past(underrunLive, 2))
    else $error("underrun bit not live in ignore mode");
  c_overflow: cover property (rdAcc && prdata[6]);
  c_take: cover property (txWordTake);
  c_halt: cover property (underrunHalt);
endmodule
bind ssfl_status_low ssfl_status_props u_ssfl_status_props (.mclk, .rst, .psel, .penable,
  .pwrite, .paddr, .prdata, .txWordValid, .txWordTake, .txShiftBusy, .linkBusy, .underrunLive,
  .moduleOn, .ignoreUnderrun, .underrunHalt);

//--- tb/ssfl_far_end.sv
// Far-side shifter: takes tx words, delivers rx words and faults
`timescale 1ns/1ps
module ssfl_far_end (
  input  wire logic   mclk,
  input  wire logic   txWordValid,
  output logic        rxWordDone = 1'b0,
  output logic [31:0] rxWord = 32'h0,
  output logic        txWordTake = 1'b0,
  output logic        txShiftBusy,
  output logic        linkBusy,
  output logic        frameErrorEvent = 1'b0,
  output logic        underrunLive = 1'b0
);
  logic       go = 1'b1;
  logic [2:0] cnt = 3'h0;
  assign txShiftBusy = cnt != 3'h0;
  assign linkBusy    = cnt != 3'h0;
  always @(posedge mclk) begin
    txWordTake <= 1'b0;
    if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
    else if (go && txWordValid && !txWordTake) begin
      txWordTake <= 1'b1;
      cnt        <= 3'h4;
    end
  end
  // Data line scrambled outside the strobe
  task automatic rxSend(input logic [31:0] w);
    @(posedge mclk);
    rxWordDone <= 1'b1;
    rxWord     <= w;
    @(posedge mclk);
    rxWordDone <= 1'b0;
    rxWord     <= ~w;
  endtask
  task automatic frameFault;
    @(posedge mclk);
    frameErrorEvent <= 1'b1;
    @(posedge mclk);
    frameErrorEvent <= 1'b0;
  endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the serial status block
`timescale 1ns/1ps
`define CMP(g, x) begin checked++; if ((g) !== (x)) begin fail_count++; \
  $display("unexpected %0t: %h not %h", $time, g, x); end end
module tb_top;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, txWord, rxWord, r;
  logic        pready, pslverr, rxWordDone, txWordTake, txShiftBusy, linkBusy, e;
  logic        frameErrorEvent, underrunLive, txWordValid, moduleOn, ignoreUnderrun, underrunHalt;
  int          fail_count = 0, checked = 0, i, n;
  localparam logic [77:0] ROWS [7] = '{{1'b0, 12'h004, 32'h0, 32'h000000A8, 1'b0},
    {1'b1, 12'h004, 32'h0000FFFF, 32'h0, 1'b0}, {1'b0, 12'h004, 32'h0, 32'h000000A8, 1'b0},
    {1'b1, 12'h000, 32'h00008008, 32'h0, 1'b0}, {1'b0, 12'h000, 32'h0, 32'h00008008, 1'b0},
    {1'b1, 12'h000, 32'h0, 32'h0, 1'b0}, {1'b0, 12'hFFC, 32'h0, 32'h0, 1'b1}};
  ssfl_status_low u_ssfl_status_low (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rxWordDone, .rxWord, .txWordTake, .txShiftBusy, .linkBusy,
    .frameErrorEvent, .underrunLive, .txWord, .txWordValid, .moduleOn, .ignoreUnderrun,
    .underrunHalt);
  ssfl_far_end u_ssfl_far_end (.mclk, .txWordValid, .rxWordDone, .rxWord, .txWordTake,
    .txShiftBusy, .linkBusy, .frameErrorEvent, .underrunLive);
  initial forever #5 mclk = ~mclk;
  task automatic results;
    $display("checked %0d failed %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 9);
    if (pready !== 1'b1) begin
      fail_count++;
      results();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] x);
    apb(1'b0, 12'h004, 32'h0);
    `CMP(r, x)
  endtask
  task automatic waitShift(input logic v);
    for (n = 0; n < 20 && txShiftBusy !== v; n++) @(posedge mclk);
    if (txShiftBusy !== v) begin
      fail_count++;
      results();
    end
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    for (i = 0; i < 7; i++) begin
      apb(ROWS[i][77], ROWS[i][76:65], ROWS[i][64:33]);
      if (!ROWS[i][77]) `CMP(r, ROWS[i][32:1])
      `CMP(e, ROWS[i][0])
    end
    $display("table done");
    u_ssfl_far_end.rxSend(32'hA5A50001);
    chk(32'h00000089);
    u_ssfl_far_end.rxSend(32'h0000005A);
    chk(32'h000000C9);
    apb(1'b0, 12'h008, 32'h0);
    `CMP(r, 32'hA5A50001)
    chk(32'h000000E8);
    apb(1'b1, 12'h004, 32'h0);
    chk(32'h000000A8);
    u_ssfl_far_end.frameFault;
    apb(1'b1, 12'h004, 32'h00001040);
    chk(32'h000010A8);
    apb(1'b1, 12'h004, 32'h0);
    chk(32'h000000A8);
    $display("rx and frame done");
    u_ssfl_far_end.go <= 1'b0;
    apb(1'b1, 12'h008, 32'h00000055);
    apb(1'b1, 12'h008, 32'h00000066);
    chk(32'h00000822);
    `CMP(txWord, 32'h00000055)
    `CMP(txWordValid, 1'b1)
    u_ssfl_far_end.go <= 1'b1;
    waitShift(1'b1);
    chk(32'h00000828);
    waitShift(1'b0);
    chk(32'h000000A8);
    $display("tx done");
    apb(1'b1, 12'h000, 32'h00008000);
    u_ssfl_far_end.underrunLive <= 1'b1;
    @(posedge mclk);
    u_ssfl_far_end.underrunLive <= 1'b0;
    chk(32'h000001A8);
    `CMP(underrunHalt, 1'b1)
    apb(1'b1, 12'h000, 32'h00008008);
    @(posedge mclk);
    `CMP({moduleOn, ignoreUnderrun}, 2'b11)
    chk(32'h000000A8);
    u_ssfl_far_end.underrunLive <= 1'b1;
    @(posedge mclk);
    chk(32'h000001A8);
    `CMP(underrunHalt, 1'b0)
    apb(1'b1, 12'h000, 32'h0);
    @(posedge mclk);
    chk(32'h000000A8);
    $display("underrun done");
    // Mid-run reset with frame error and underrun flags, rx buffer and control all non-default
    apb(1'b1, 12'h000, 32'h00008008);
    u_ssfl_far_end.rxSend(32'h00000011);
    u_ssfl_far_end.frameFault;
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    chk(32'h000000A8);
    apb(1'b0, 12'h000, 32'h0);
    `CMP(r, 32'h00000000)
    $display("reset done");
    results();
  end
endmodule
